// ==== verilog/vpl_defines.svh ====
// constants for the vital product pages and log clear command path
`ifndef VPL_DEFINES_SVH
`define VPL_DEFINES_SVH

`define VPL_OP_INQUIRY 8'h12
`define VPL_OP_LOG_CLEAR 8'h4c
`define VPL_PAGE_MEDIA 8'hd1
`define VPL_PAGE_CARD 8'hd2
`define VPL_PAGE_CACHE 8'hd9
`define VPL_LEN_MEDIA 8'h50
`define VPL_LEN_CARD 8'h34
`define VPL_LEN_CACHE 8'h1c
`define VPL_STR_LEN 8'h10
`define VPL_BYTE0 8'h00
`define VPL_SPACE 8'h20
`define VPL_PC_CURRENT 2'b01
`define VPL_PC_DEFAULT 2'b11
`define VPL_SK_ILLEGAL 4'h5
`define VPL_ASC_BAD_OPCODE 8'h20
`define VPL_ASC_BAD_CDB 8'h24
`define VPL_CDB_VITAL_PRODUCT_SELECT_BIT 0
`define VPL_CDB_RESET_BIT 1
`define VPL_CDB_SAVE_BIT 0
`define VPL_WB_CTRL 8'h00
`define VPL_WB_STATUS 8'h04
`define VPL_WB_CDB0 8'h08
`define VPL_WB_CDB1 8'h0c
`define VPL_WB_CDB2 8'h10
`define VPL_WB_DIDX 8'h14
`define VPL_WB_DATA 8'h18

`endif

// ==== verilog/vpl_pkg.sv ====
// shared types of the vital product pages and log clear path
package vpl_pkg;
	typedef logic [9:0][7:0] vpl_cdb_t;
	typedef logic [15:0][7:0] vpl_str_t;
	typedef enum logic [1:0] {
		VPL_IDLE,
		VPL_STREAM,
		VPL_RESP
	} vpl_state_t;
endpackage

// ==== verilog/vpl_if.sv ====
// link between initiator end and target end
`timescale 1ns/1ps
interface vpl_if #(
	parameter int NI = 4
);
	import vpl_pkg::*;
	logic cmd_valid;
	vpl_cdb_t cdb;
	logic [$clog2(NI)-1:0] init_id;
	logic busy;
	logic din_valid;
	logic [7:0] din_byte;
	logic done;
	logic check;
	logic [3:0] sense_key;
	logic [7:0] asc;
	modport initiator (output cmd_valid, cdb, init_id, input busy, din_valid, din_byte, done, check, sense_key, asc);
	modport target (input cmd_valid, cdb, init_id, output busy, din_valid, din_byte, done, check, sense_key, asc);
endinterface

// ==== verilog/vpl_page_rom.sv ====
// byte generator for the three vendor pages
`timescale 1ns/1ps
`include "vpl_defines.svh"
module vpl_page_rom
	import vpl_pkg::*;
(
	input wire logic [7:0] page_i,
	input wire logic [6:0] idx_i,
	input wire logic media_ok_i,
	input wire logic cache_en_i,
	input wire vpl_str_t media_def_i,
	input wire vpl_str_t motor_sn_i,
	input wire vpl_str_t flex_sn_i,
	input wire vpl_str_t actuator_sn_i,
	input wire vpl_str_t enclosure_sn_i,
	input wire vpl_str_t controller_version_string_i,
	input wire vpl_str_t card_sn_i,
	input wire vpl_str_t card_pn_i,
	input wire vpl_str_t fw_version_i,
	output logic [7:0] byte_o
);
	// non alphanumeric characters, trailing nulls included, become blanks
	function automatic logic [7:0] clean(input vpl_str_t s, input logic [6:0] pos);
		logic [7:0] c;
		c = s[pos[3:0]];
		if ((c >= 8'h30 && c <= 8'h39) || (c >= 8'h41 && c <= 8'h5a) || (c >= 8'h61 && c <= 8'h7a)) begin
			return c;
		end
		return `VPL_SPACE;
	endfunction

	always_comb begin
		byte_o = `VPL_BYTE0;
		if (idx_i == 7'd0) begin
			byte_o = `VPL_BYTE0;
		end else if (idx_i == 7'd1) begin
			byte_o = page_i;
		end else if (idx_i == 7'd2) begin
			byte_o = `VPL_BYTE0;
		end else if (idx_i == 7'd3) begin
			case (page_i)
				`VPL_PAGE_MEDIA: byte_o = `VPL_LEN_MEDIA;
				`VPL_PAGE_CARD: byte_o = `VPL_LEN_CARD;
				default: byte_o = `VPL_LEN_CACHE;
			endcase
		end else if (!media_ok_i) begin
			byte_o = `VPL_SPACE;
		end else begin
			case (page_i)
				`VPL_PAGE_MEDIA: begin
					if (idx_i < 7'd20) byte_o = clean(media_def_i, idx_i - 7'd4);
					else if (idx_i < 7'd36) byte_o = clean(motor_sn_i, idx_i - 7'd20);
					else if (idx_i < 7'd52) byte_o = clean(flex_sn_i, idx_i - 7'd36);
					else if (idx_i < 7'd68) byte_o = clean(actuator_sn_i, idx_i - 7'd52);
					else byte_o = clean(enclosure_sn_i, idx_i - 7'd68);
				end
				`VPL_PAGE_CARD: begin
					if (idx_i == 7'd4 || idx_i == 7'd21 || idx_i == 7'd38) byte_o = `VPL_STR_LEN;
					else if (idx_i < 7'd21) byte_o = clean(controller_version_string_i, idx_i - 7'd5);
					else if (idx_i < 7'd38) byte_o = clean(card_sn_i, idx_i - 7'd22);
					else if (idx_i < 7'd55) byte_o = clean(card_pn_i, idx_i - 7'd39);
					else byte_o = `VPL_BYTE0;
				end
				default: begin
					if (idx_i == 7'd4) byte_o = {7'h00, cache_en_i};
					else if (idx_i < 7'd16) byte_o = `VPL_BYTE0;
					else byte_o = clean(fw_version_i, idx_i - 7'd16);
				end
			endcase
		end
	end
endmodule

// ==== verilog/vpl_target.sv ====
// target end: vendor page replies and log clear decode
//
// Functional notes
// - byte 0 reads zero on every page
// - byte 1 echoes the requested page code
// - media page byte 2 zero, length 80
// - five 16-byte identity strings, fixed order
// - media absent: bytes 4 onward are blanks
// - strings alphanumeric, left aligned, blank padded
// - card page byte 2 zero, length 52
// - three length-prefixed strings, byte 55 zero
// - byte 4 bit 0 shows flash cache enabled
// - bytes 16-31 hold firmware version
// - opcode 4ch decoded as log clear
// - counter reset clears, flags other initiators
// - no counter reset: no clear unless 11b
// - initiator sends zero length with counter reset
// - list parameters ignore page control
// - save bit gates saving changed parameters
// - nonzero length without save bit: check
// - page control 11b clears default values
// - 01b with counter reset clears current values
// - page control 11b needs zero length
// - unsupported page code: check condition
// - unit attention to all but issuer
//
// The placing of the registers and the Wishbone interface to the registers were left to the implementer.
`timescale 1ns/1ps
`include "vpl_defines.svh"
module vpl_target
	import vpl_pkg::*;
#(
	parameter int NI = 4
) (
	input wire logic ref_clk_i,
	input wire logic reset_i,
	vpl_if.target link,
	input wire logic media_ok_i,
	input wire logic flash_backed_cache_flag_i,
	input wire vpl_str_t media_def_i,
	input wire vpl_str_t motor_sn_i,
	input wire vpl_str_t flex_sn_i,
	input wire vpl_str_t actuator_sn_i,
	input wire vpl_str_t enclosure_sn_i,
	input wire vpl_str_t controller_version_string_i,
	input wire vpl_str_t card_sn_i,
	input wire vpl_str_t card_pn_i,
	input wire vpl_str_t fw_version_i,
	output logic clear_current_o,
	output logic clear_default_o,
	output logic clear_list_o,
	output logic save_o,
	output logic [NI-1:0] unit_attention_o
);
	if (NI < 2) begin : g_chk
		$error("vpl_target needs at least two initiators");
	end

	typedef struct packed {
		vpl_state_t state;
		logic [7:0] page;
		logic [6:0] idx;
		logic [6:0] last;
		logic busy;
		logic din_valid;
		logic [7:0] din_byte;
		logic done;
		logic check;
		logic [3:0] sense_key;
		logic [7:0] asc;
		logic clr_cur;
		logic clr_def;
		logic clr_list;
		logic save;
		logic [NI-1:0] ua;
	} vpl_tgt_st_t;

	vpl_tgt_st_t q, d;
	logic [7:0] rom_byte;

	// log pages that can be cleared
	function automatic logic log_page_ok(input logic [7:0] p);
		case (p)
			8'h00, 8'h02, 8'h03, 8'h05, 8'h06, 8'h0e, 8'h0f, 8'h15, 8'h18, 8'h30, 8'h37: return 1'b1;
			default: return 1'b0;
		endcase
	endfunction

	function automatic logic vpd_page_ok(input logic [7:0] p);
		return p == `VPL_PAGE_MEDIA || p == `VPL_PAGE_CARD || p == `VPL_PAGE_CACHE;
	endfunction

	vpl_page_rom u_rom (
		.page_i(q.page),
		.idx_i(q.idx),
		.media_ok_i(media_ok_i),
		.cache_en_i(flash_backed_cache_flag_i),
		.media_def_i(media_def_i),
		.motor_sn_i(motor_sn_i),
		.flex_sn_i(flex_sn_i),
		.actuator_sn_i(actuator_sn_i),
		.enclosure_sn_i(enclosure_sn_i),
		.controller_version_string_i(controller_version_string_i),
		.card_sn_i(card_sn_i),
		.card_pn_i(card_pn_i),
		.fw_version_i(fw_version_i),
		.byte_o(rom_byte)
	);

	always_comb begin
		logic reset_bit;
		logic save_bit;
		logic [1:0] page_control_field;
		logic [7:0] pcode;
		logic [15:0] plen;
		logic bad;
		logic change;
		reset_bit = link.cdb[1][`VPL_CDB_RESET_BIT];
		save_bit = link.cdb[1][`VPL_CDB_SAVE_BIT];
		page_control_field = link.cdb[2][7:6];
		pcode = link.cdb[2];
		plen = {link.cdb[7], link.cdb[8]};
		bad = 1'b0;
		change = 1'b0;
		d = q;
		d.din_valid = 1'b0;
		d.done = 1'b0;
		d.clr_cur = 1'b0;
		d.clr_def = 1'b0;
		d.clr_list = 1'b0;
		d.save = 1'b0;
		d.ua = '0;
		case (q.state)
			VPL_IDLE: begin
				if (link.cmd_valid) begin
					d.check = 1'b0;
					d.sense_key = 4'h0;
					d.asc = 8'h00;
					d.state = VPL_RESP;
					if (link.cdb[0] == `VPL_OP_INQUIRY) begin
						if (link.cdb[1][`VPL_CDB_VITAL_PRODUCT_SELECT_BIT] && vpd_page_ok(pcode)) begin
							d.page = pcode;
							d.idx = 7'd0;
							d.state = VPL_STREAM;
							case (pcode)
								`VPL_PAGE_MEDIA: d.last = 7'(`VPL_LEN_MEDIA + 8'd3);
								`VPL_PAGE_CARD: d.last = 7'(`VPL_LEN_CARD + 8'd3);
								default: d.last = 7'(`VPL_LEN_CACHE + 8'd3);
							endcase
						end else begin
							bad = 1'b1;
						end
					end else if (link.cdb[0] == `VPL_OP_LOG_CLEAR) begin
						pcode = {2'b00, link.cdb[2][5:0]};
						if (!log_page_ok(pcode)) bad = 1'b1;
						if (plen != 16'h0000 && !save_bit) bad = 1'b1;
						if (page_control_field == `VPL_PC_DEFAULT && plen != 16'h0000) bad = 1'b1;
						if (reset_bit && plen != 16'h0000) bad = 1'b1;
						if (!bad) begin
							d.clr_def = page_control_field == `VPL_PC_DEFAULT;
							d.clr_cur = reset_bit;
							d.clr_list = reset_bit;
							change = reset_bit || page_control_field == `VPL_PC_DEFAULT;
							d.save = save_bit && change;
							if (change) begin
								d.ua = ~(NI'(1) << link.init_id);
							end
						end
					end else begin
						d.check = 1'b1;
						d.sense_key = `VPL_SK_ILLEGAL;
						d.asc = `VPL_ASC_BAD_OPCODE;
					end
					if (bad) begin
						d.check = 1'b1;
						d.sense_key = `VPL_SK_ILLEGAL;
						d.asc = `VPL_ASC_BAD_CDB;
					end
				end
			end
			VPL_STREAM: begin
				d.din_valid = 1'b1;
				d.din_byte = rom_byte;
				d.idx = q.idx + 7'd1;
				if (q.idx == q.last) begin
					d.state = VPL_RESP;
				end
			end
			VPL_RESP: begin
				d.done = 1'b1;
				d.state = VPL_IDLE;
			end
			default: begin
				d.state = VPL_IDLE;
			end
		endcase
		d.busy = d.state != VPL_IDLE;
	end

	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign link.busy = q.busy;
	assign link.din_valid = q.din_valid;
	assign link.din_byte = q.din_byte;
	assign link.done = q.done;
	assign link.check = q.check;
	assign link.sense_key = q.sense_key;
	assign link.asc = q.asc;
	assign clear_current_o = q.clr_cur;
	assign clear_default_o = q.clr_def;
	assign clear_list_o = q.clr_list;
	assign save_o = q.save;
	assign unit_attention_o = q.ua;
endmodule

// ==== verilog/vpl_initiator.sv ====
// initiator end: wishbone registers that issue commands and gather replies
`timescale 1ns/1ps
`include "vpl_defines.svh"
module vpl_initiator
	import vpl_pkg::*;
#(
	parameter int NI = 4,
	parameter int DEPTH = 128
) (
	input wire logic ref_clk_i,
	input wire logic reset_i,
	vpl_if.initiator link,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [3:0] wb_sel_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o
);
	if (DEPTH < 84 || DEPTH > 256) begin : g_chk
		$error("vpl_initiator buffer depth must be 84 to 256");
	end

	typedef struct packed {
		logic [DEPTH-1:0][7:0] buffer;
		logic [8:0] count;
		logic [7:0] didx;
		logic [9:0][7:0] cdb;
		logic [$clog2(NI)-1:0] init_id;
		logic cmd_valid;
		logic busy;
		logic done;
		logic check;
		logic [3:0] sense_key;
		logic [7:0] asc;
		logic ack;
		logic [31:0] rdata;
	} vpl_ini_st_t;

	vpl_ini_st_t q, d;

	// byte lane merge for writes
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) old[i*8 +: 8] = nw[i*8 +: 8];
		end
		return old;
	endfunction

	always_comb begin
		logic [31:0] w;
		logic req;
		w = 32'h0000_0000;
		req = wb_cyc_i && wb_stb_i && !q.ack;
		d = q;
		d.cmd_valid = 1'b0;
		d.ack = req;
		if (link.din_valid && q.count < 9'(DEPTH)) begin
			d.buffer[q.count[$clog2(DEPTH)-1:0]] = link.din_byte;
			d.count = q.count + 9'd1;
		end
		if (link.done) begin
			d.busy = 1'b0;
			d.done = 1'b1;
			d.check = link.check;
			d.sense_key = link.sense_key;
			d.asc = link.asc;
		end
		if (req && wb_we_i) begin
			case (wb_adr_i)
				`VPL_WB_CTRL: begin
					if (wb_sel_i[0] && wb_dat_i[0] && !q.busy && !link.busy) begin
						d.cmd_valid = 1'b1;
						d.busy = 1'b1;
						d.done = 1'b0;
						d.count = 9'd0;
					end
				end
				`VPL_WB_CDB0: begin
					w = merge({q.cdb[3], q.cdb[2], q.cdb[1], q.cdb[0]}, wb_dat_i, wb_sel_i);
					{d.cdb[3], d.cdb[2], d.cdb[1], d.cdb[0]} = w;
				end
				`VPL_WB_CDB1: begin
					w = merge({q.cdb[7], q.cdb[6], q.cdb[5], q.cdb[4]}, wb_dat_i, wb_sel_i);
					{d.cdb[7], d.cdb[6], d.cdb[5], d.cdb[4]} = w;
				end
				`VPL_WB_CDB2: begin
					w = merge({8'h00, 8'(q.init_id), q.cdb[9], q.cdb[8]}, wb_dat_i, wb_sel_i);
					{d.cdb[9], d.cdb[8]} = w[15:0];
					d.init_id = w[16 +: $clog2(NI)];
				end
				`VPL_WB_DIDX: begin
					if (wb_sel_i[0]) d.didx = wb_dat_i[7:0];
				end
				default: begin
					d.didx = d.didx;
				end
			endcase
		end
		d.rdata = 32'h0000_0000;
		if (req && !wb_we_i) begin
			case (wb_adr_i)
				`VPL_WB_STATUS: d.rdata = {7'h00, q.count, q.asc, q.sense_key, 1'b0, q.check, q.done, q.busy};
				`VPL_WB_CDB0: d.rdata = {q.cdb[3], q.cdb[2], q.cdb[1], q.cdb[0]};
				`VPL_WB_CDB1: d.rdata = {q.cdb[7], q.cdb[6], q.cdb[5], q.cdb[4]};
				`VPL_WB_CDB2: d.rdata = {8'h00, 8'(q.init_id), q.cdb[9], q.cdb[8]};
				`VPL_WB_DIDX: d.rdata = {24'h00_0000, q.didx};
				`VPL_WB_DATA: begin
					if (9'(q.didx) < 9'(DEPTH)) d.rdata = {24'h00_0000, q.buffer[q.didx[$clog2(DEPTH)-1:0]]};
				end
				default: d.rdata = 32'h0000_0000;
			endcase
		end else if (!req) begin
			d.rdata = q.rdata;
		end
	end

	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign link.cmd_valid = q.cmd_valid;
	assign link.cdb = q.cdb;
	assign link.init_id = q.init_id;
	assign wb_dat_o = q.rdata;
	assign wb_ack_o = q.ack;
endmodule

// ==== dv/vpl_pages_and_log_clear_assertions.sv ====
// link checks for page replies and log clear
`timescale 1ns/1ps
module vpl_checker
	import vpl_pkg::*;
(
	input wire logic ref_clk_i,
	input wire logic reset_i,
	input wire logic cmd_valid,
	input wire vpl_cdb_t cdb,
	input wire logic busy,
	input wire logic din_valid,
	input wire logic [7:0] din_byte,
	input wire logic done,
	input wire logic check,
	input wire logic [3:0] sense_key,
	input wire logic [7:0] asc
);
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (reset_i);
	logic tk, lc, inq, nz, pok;
	assign tk = cmd_valid && !busy;
	assign lc = tk && cdb[0] == 8'h4c;
	assign inq = tk && cdb[0] == 8'h12 && cdb[1][0];
	assign nz = {cdb[7], cdb[8]} != 16'h0000;
	assign pok = cdb[2][5:0] inside {6'h00, 6'h02, 6'h03, 6'h05, 6'h06, 6'h0e, 6'h0f, 6'h15, 6'h18, 6'h30, 6'h37};
	sequence s_hdr(logic [7:0] pg, logic [7:0] ln);
		din_valid && din_byte == 8'h00 ##1 din_valid && din_byte == pg
		##1 din_valid && din_byte == 8'h00 ##1 din_valid && din_byte == ln;
	endsequence
	sequence s_bad;
		done && check && sense_key == 4'h5 && asc == 8'h24;
	endsequence
	property p_busy; lc |=> busy ##1 done && !busy; endproperty
	property p_d1; inq && cdb[2] == 8'hd1 |-> ##2 s_hdr(8'hd1, 8'h50); endproperty
	property p_d2; inq && cdb[2] == 8'hd2 |-> ##2 s_hdr(8'hd2, 8'h34); endproperty
	property p_d9; inq && cdb[2] == 8'hd9 |-> ##2 s_hdr(8'hd9, 8'h1c); endproperty
	property p_d1_end; inq && cdb[2] == 8'hd1 |-> ##86 done && !check; endproperty
	property p_save; lc && !cdb[1][0] && nz |-> ##2 s_bad; endproperty
	property p_pc11; lc && cdb[2][7:6] == 2'b11 && nz |-> ##2 s_bad; endproperty
	property p_page; lc && !pok |-> ##2 s_bad; endproperty
	property p_ok; lc && pok && !nz |-> ##2 done && !check; endproperty
	a_busy: assert property (p_busy) else $error("log clear timing");
	a_d1: assert property (p_d1) else $error("media page header");
	a_d2: assert property (p_d2) else $error("card page header");
	a_d9: assert property (p_d9) else $error("cache page header");
	a_d1_end: assert property (p_d1_end) else $error("media page size");
	a_save: assert property (p_save) else $error("length without save");
	a_pc11: assert property (p_pc11) else $error("default control with length");
	a_page: assert property (p_page) else $error("bad page accepted");
	a_ok: assert property (p_ok) else $error("legal clear refused");
endmodule

// ==== dv/vpl_pages_and_log_clear_tb_top.sv ====
// bench driving the initiator registers against the target end
`timescale 1ns/1ps
module vpl_pages_and_log_clear_tb_top
	import vpl_pkg::*;
;
	logic ref_clk_i = 1'b0;
	logic reset_i = 1'b1;
	logic cyc = 1'b0, stb = 1'b0, we = 1'b0, m_ok = 1'b1, fl = 1'b1;
	logic [7:0] adr = 8'h00;
	logic [31:0] dat = 32'h0, rdat, st, q;
	logic [3:0] sel = 4'h0, ua, pul, ua_s, pul_s;
	logic ack, cc, cd, cl, sv;
	int n_fail = 0, total_checks = 0;
	// cdb1, cdb2, length, {check, current, default, list, save}
	logic [31:0] tab [10] = '{32'h0240000a, 32'h0340000b, 32'h00c20004, 32'h01430000, 32'h00400410,
		32'h01c00410, 32'h03400410, 32'h02410010, 32'h02c0000e, 32'h03c2000f};
	always #2.5 ref_clk_i = ~ref_clk_i;
	vpl_if #(.NI(4)) u_link();
	function automatic logic [7:0] sc(int j, int p);
		return p < 7 ? 8'(8'h41 + j + p) : 8'h20;
	endfunction
	function automatic vpl_str_t mk(int j);
		vpl_str_t s;
		for (int p = 0; p < 16; p++) begin
			// a dash must come back as a blank
			s[p] = p == 7 ? 8'h2d : sc(j, p);
		end
		return s;
	endfunction
	function automatic logic [7:0] eb(logic [7:0] pg, int i, logic ok);
		if (i < 4)
			return i == 1 ? pg : i != 3 ? 8'h00 : pg == 8'hd1 ? 8'h50 : pg == 8'hd2 ? 8'h34 : 8'h1c;
		if (!ok)
			return 8'h20;
		if (pg == 8'hd1)
			return sc((i - 4) / 16, (i - 4) % 16);
		if (pg == 8'hd2)
			return i == 55 ? 8'h00 : (i - 4) % 17 == 0 ? 8'h10 : sc(5 + (i - 4) / 17, (i - 5) % 17);
		return i == 4 ? {7'h00, ok} : i < 16 ? 8'h00 : sc(8, i - 16);
	endfunction
	vpl_target #(.NI(4)) u_vpl_target(.ref_clk_i, .reset_i, .link(u_link), .media_ok_i(m_ok),
		.flash_backed_cache_flag_i(fl), .media_def_i(mk(0)), .motor_sn_i(mk(1)), .flex_sn_i(mk(2)),
		.actuator_sn_i(mk(3)), .enclosure_sn_i(mk(4)), .controller_version_string_i(mk(5)), .card_sn_i(mk(6)),
		.card_pn_i(mk(7)), .fw_version_i(mk(8)), .clear_current_o(cc), .clear_default_o(cd), .clear_list_o(cl),
		.save_o(sv), .unit_attention_o(ua));
	vpl_initiator #(.NI(4), .DEPTH(128)) u_vpl_initiator(.ref_clk_i, .reset_i, .link(u_link),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(sel),
		.wb_dat_o(rdat), .wb_ack_o(ack));
	vpl_checker u_vpl_checker(.ref_clk_i, .reset_i, .cmd_valid(u_link.cmd_valid), .cdb(u_link.cdb),
		.busy(u_link.busy), .din_valid(u_link.din_valid), .din_byte(u_link.din_byte), .done(u_link.done),
		.check(u_link.check), .sense_key(u_link.sense_key), .asc(u_link.asc));
	// pulses gathered per command, cleared as a command is issued
	assign pul = {cc, cd, cl, sv};
	always @(posedge ref_clk_i) begin
		pul_s <= u_link.cmd_valid ? 4'h0 : pul_s | pul;
		ua_s <= u_link.cmd_valid ? 4'h0 : ua_s | ua;
	end
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		total_checks++;
		if (s !== e) begin
			n_fail++;
			$display("BAD t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		sel <= 4'hf;
		@(posedge ref_clk_i);
		while (ack !== 1'b1) begin
			@(posedge ref_clk_i);
		end
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task automatic run(input logic [31:0] c0, input logic [31:0] c1, input logic [31:0] c2);
		int n;
		wb(1'b1, 8'h08, c0);
		wb(1'b1, 8'h0c, c1);
		wb(1'b1, 8'h10, c2);
		wb(1'b1, 8'h00, 32'h1);
		n = 0;
		st = 32'h0;
		while (st[1] !== 1'b1 && n < 300) begin
			wb(1'b0, 8'h04, 32'h0);
			st = q;
			n++;
		end
	endtask
	task automatic results();
		if (n_fail == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial begin
		logic [7:0] pg;
		int nb;
		repeat (4) @(posedge ref_clk_i);
		reset_i <= 1'b0;
		for (int m = 0; m < 2; m++) begin
			m_ok <= m == 0;
			fl <= m == 0;
			for (int k = 0; k < 3; k++) begin
				pg = k == 0 ? 8'hd1 : k == 1 ? 8'hd2 : 8'hd9;
				nb = k == 0 ? 84 : k == 1 ? 56 : 32;
				run({8'h00, pg, 8'h01, 8'h12}, 32'h0, 32'h0);
				chk(st[24:16], nb);
				for (int i = 0; i < nb; i++) begin
					wb(1'b1, 8'h14, 32'(i));
					wb(1'b0, 8'h18, 32'h0);
					chk(q, eb(pg, i, m == 0));
				end
			end
		end
		// media present, flash cache off
		m_ok <= 1'b1;
		fl <= 1'b0;
		run({8'h00, 8'hd9, 8'h01, 8'h12}, 32'h0, 32'h0);
		wb(1'b1, 8'h14, 32'h4);
		wb(1'b0, 8'h18, 32'h0);
		chk(q, 32'h0);
		run({8'h00, 8'h40, 8'h02, 8'h4d}, 32'h0, 32'h0);
		chk({st[15:4], st[2]}, {8'h20, 4'h5, 1'b1});
		for (int k = 0; k < 10; k++) begin
			run({8'h00, tab[k][23:16], tab[k][31:24], 8'h4c}, 32'h0, {8'h00, 8'(k % 4), 8'h00, tab[k][15:8]});
			chk(st[2], tab[k][4]);
			if (tab[k][4])
				chk(st[15:4], 12'h245);
			chk(pul_s, tab[k][3:0]);
			chk(ua_s, tab[k][3:2] != 2'b00 ? 4'hf & ~(4'h1 << (k % 4)) : 4'h0);
		end
		wb(1'b0, 8'hfc, 32'h0);
		chk(q, 32'h0);
		results();
	end
	initial begin
		#100000;
		n_fail++;
		results();
	end
endmodule
